/* File: rtl/icsam_cfg.svh */
/*
 Register indices, field positions, reset values and command codes
 for the two-wire client status and address match block.
 Assumes word-aligned APB access: byte address is four times an index.
*/
`ifndef ICSAM_CFG_SVH
`define ICSAM_CFG_SVH

`define ICSAM_IDX_CTRLA    6'h09
`define ICSAM_IDX_CTRLB    6'h0A
`define ICSAM_IDX_STATUS   6'h0B
`define ICSAM_IDX_ADDR     6'h0C
`define ICSAM_IDX_DATA     6'h0D
`define ICSAM_IDX_MASK     6'h0E
`define ICSAM_IDX_EXT      6'h0F

`define ICSAM_RST_BYTE     8'h00
`define ICSAM_CTRLA_MASK   8'hE7

`define ICSAM_CA_ENABLE    0
`define ICSAM_CA_SMART_MODE_ENABLE      1
`define ICSAM_CA_PROMISCUOUS_ADDRESS_MODE      2
`define ICSAM_CA_STOP_REPORTING_ENABLE      5
`define ICSAM_CB_ACKNOWLEDGE_ACTION    2

`define ICSAM_ST_DIF       7
`define ICSAM_ST_ADDRESS_OR_STOP_FLAG      6
`define ICSAM_ST_COLLISION_BIT      3
`define ICSAM_ST_BUS_ERROR_FLAG    2

`define ICSAM_CMD_NONE     2'h0
`define ICSAM_CMD_COMPLETE 2'h2
`define ICSAM_CMD_RESPONSE 2'h3
`define ICSAM_BITS         4'h8

`endif

/* File: rtl/icsam_client.sv */
/*
 Two-wire client: status flags, address match, data register with
 clock hold, smart-mode acknowledge, APB register slave.
 Assumes an APB master on clk_sys and an external host on the bus;
 the bus wires resolve from the open-drain enables outside.
*/
// The APB slave port was left to the implementer.
// How it works
// - byte done or lost high bit sets data flag
// - data access or command clears data flag
// - address match or reported stop sets flag
// - same accesses clear address-or-stop flag
// - hold state holds SCL low; command, smart read or transmit-phase data write releases
// - received acknowledge shows host ACK/NACK
// - lost high bit sets collision, ends transfer
// - NACK overridden after match sets collision
// - collision cleared by write one, start
// - illegal start/stop sequence sets bus error
// - bus error only with dual/host enabled
// - direction holds last address read/write bit
// - cause reads 0 stop, 1 address
// - matching address sets flag and cause
// - primary address; bit 0 enables general call
// - smart read under hold runs acknowledge
// - mask bits exclude address bits from compare
// - second address enable adds second address
// - promiscuous mode accepts every address
// - acknowledge action 0 ACK, 1 NACK
// - command 2 completes, command 3 continues
// - stop sets flag only when reporting enabled
`timescale 1ns/10ps
`default_nettype none
`include "icsam_cfg.svh"

module icsam_client
(
    // system
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    input  wire logic                      ce,
    // register bus
    input  wire icsam_pkg::icsam_apb_req_t apb_req,
    output var  icsam_pkg::icsam_apb_rsp_t apb_rsp,
    // two-wire pins
    input  wire logic                      scl_in,
    input  wire logic                      sda_in,
    output var  icsam_pkg::icsam_pins_t    pins
);
    import icsam_pkg::*;

    logic [1:0]   line_s;
    logic         scl_d;
    logic         sda_d;
    icsam_state_t state;
    icsam_state_t next_state;
    icsam_phase_t phase;
    icsam_phase_t next_phase;
    logic [3:0]   bitcnt;
    logic [3:0]   next_bitcnt;
    logic [7:0]   shreg;
    logic [7:0]   next_shreg;
    logic         ack_nack;
    logic         next_nack;
    logic         ack_fin;
    logic         next_fin;
    logic [7:0]   addr_reg;
    logic [7:0]   data_reg;
    logic [7:0]   mask_reg;
    logic [7:0]   ctrla;
    logic         acknowledge_action;
    logic         ext_en;
    logic         data_flag;
    logic         address_or_stop_flag;
    logic         received_acknowledge;
    logic         collision_bit;
    logic         bus_error_flag;
    logic         dir;
    logic         ap;
    logic         addr_match;

    // line events
    wire logic scl_s     = line_s[1];
    wire logic sda_s     = line_s[0];
    wire logic scl_rise  = scl_s && !scl_d;
    wire logic scl_fall  = !scl_s && scl_d;
    wire logic start_det = scl_s && scl_d && sda_d && !sda_s;
    wire logic stop_det  = scl_s && scl_d && !sda_d && sda_s;

    // bus decode
    wire logic       acc    = apb_req.psel && apb_req.penable
                              && apb_rsp.pready;
    wire logic       wr     = acc && apb_req.pwrite;
    wire logic       rd     = acc && !apb_req.pwrite;
    wire logic [5:0] idx    = apb_req.paddr[7:2];
    wire logic       algn   = apb_req.paddr[1:0] == 2'h0;
    wire logic       hit_ca = algn && idx == `ICSAM_IDX_CTRLA;
    wire logic       hit_cb = algn && idx == `ICSAM_IDX_CTRLB;
    wire logic       hit_st = algn && idx == `ICSAM_IDX_STATUS;
    wire logic       hit_ad = algn && idx == `ICSAM_IDX_ADDR;
    wire logic       hit_da = algn && idx == `ICSAM_IDX_DATA;
    wire logic       hit_mk = algn && idx == `ICSAM_IDX_MASK;
    wire logic       hit_ex = algn && idx == `ICSAM_IDX_EXT;
    wire logic       hit_any = hit_ca || hit_cb || hit_st || hit_ad
                               || hit_da || hit_mk || hit_ex;
    wire logic [7:0] wdat   = apb_req.pwdata[7:0];
    wire logic [1:0] cmd    = wdat[1:0];

    // software actions
    wire logic data_rd  = rd && hit_da;
    wire logic data_wr  = wr && hit_da;
    wire logic cmd_wr   = wr && hit_cb && cmd != `ICSAM_CMD_NONE;
    wire logic stat_wr  = wr && hit_st;
    wire logic flag_clr = data_rd || data_wr || cmd_wr;
    wire logic enable   = ctrla[`ICSAM_CA_ENABLE];
    wire logic smart    = ctrla[`ICSAM_CA_SMART_MODE_ENABLE];
    wire logic act_nack = (wr && hit_cb) ? wdat[`ICSAM_CB_ACKNOWLEDGE_ACTION]
                                         : acknowledge_action;
    wire logic go_done  = cmd_wr && cmd == `ICSAM_CMD_COMPLETE;
    wire logic go_on    = (cmd_wr && cmd == `ICSAM_CMD_RESPONSE)
                          || (data_rd && smart)
                          || (data_wr && phase == PH_TX);
    wire logic [7:0] tx_byte = data_wr ? wdat : data_reg;

    // protocol events
    wire logic byte_full = bitcnt == `ICSAM_BITS;
    wire logic addr_done = state == ST_ADDR && scl_fall && byte_full;
    wire logic addr_hit  = addr_done && addr_match;
    wire logic tx_collision_bit   = state == ST_TX && scl_rise
                           && shreg[7] && !sda_s;
    wire logic ack_collision_bit  = state == ST_ACK && scl_rise
                           && ack_nack && !sda_s;
    wire logic set_collision_bit  = tx_collision_bit || ack_collision_bit;
    wire logic set_dif   = (state == ST_RX && scl_fall && byte_full)
                           || (state == ST_TXACK && scl_fall)
                           || (state == ST_ACK && scl_fall && !ack_nack
                               && !ack_fin && phase == PH_ADDR && dir)
                           || tx_collision_bit;
    wire logic stop_rep  = stop_det && enable
                           && ctrla[`ICSAM_CA_STOP_REPORTING_ENABLE];
    wire logic set_address_or_stop_flag  = addr_hit || stop_rep;
    wire logic set_berr  = stop_det && ext_en && state == ST_ADDR
                           && bitcnt == 4'h0;
    wire logic clock_hold = state == ST_HOLD;
    wire logic drive_low  = (state == ST_ACK && !ack_nack)
                            || (state == ST_TX && !shreg[7]);

    // read mux
    wire logic [7:0] status_rd = {data_flag, address_or_stop_flag, clock_hold, received_acknowledge,
                                  collision_bit, bus_error_flag, dir, ap};
    wire logic [7:0] rd_mux =
        hit_ca ? ctrla :
        hit_cb ? {5'h00, acknowledge_action, 2'h0} :
        hit_st ? status_rd :
        hit_ad ? addr_reg :
        hit_da ? data_reg :
        hit_mk ? mask_reg :
        hit_ex ? {7'h00, ext_en} : 8'h00;

    icsam_sync #(.W(2)) u_sync
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ce      (ce),
        .d       ({scl_in, sda_in}),
        .q       (line_s)
    );

    icsam_match u_match
    (
        .rx_addr  (shreg[7:1]),
        .own_addr (addr_reg),
        .mask_reg (mask_reg),
        .promisc  (ctrla[`ICSAM_CA_PROMISCUOUS_ADDRESS_MODE]),
        .hit      (addr_match)
    );

    // protocol sequencing
    always_comb
    begin
        next_state  = state;
        next_phase  = phase;
        next_bitcnt = bitcnt;
        next_shreg  = shreg;
        next_nack   = ack_nack;
        next_fin    = ack_fin;
        unique case (state)
            ST_IDLE:
                next_state = ST_IDLE;
            ST_ADDR, ST_RX:
            begin
                if (scl_rise)
                begin
                    next_shreg  = {shreg[6:0], sda_s};
                    next_bitcnt = bitcnt + 4'h1;
                end
                else if (scl_fall && byte_full)
                begin
                    next_bitcnt = 4'h0;
                    if (state == ST_RX || addr_match)
                        next_state = ST_HOLD;
                    else
                        next_state = ST_IDLE;
                end
            end
            ST_HOLD:
            begin
                if (go_done)
                begin
                    next_state = (phase == PH_TX) ? ST_IDLE : ST_ACK;
                    next_nack  = act_nack;
                    next_fin   = 1'b1;
                end
                else if (go_on && phase == PH_TX)
                begin
                    next_state  = ST_TX;
                    next_shreg  = tx_byte;
                    next_bitcnt = 4'h0;
                end
                else if (go_on)
                begin
                    next_state = ST_ACK;
                    next_nack  = act_nack;
                    next_fin   = 1'b0;
                end
            end
            ST_ACK:
            begin
                if (scl_fall)
                begin
                    if (ack_nack || ack_fin)
                        next_state = ST_IDLE;
                    else if (phase == PH_ADDR && dir)
                    begin
                        next_phase = PH_TX;
                        next_state = ST_HOLD;
                    end
                    else
                    begin
                        next_phase = PH_RX;
                        next_state = ST_RX;
                    end
                end
            end
            ST_TX:
            begin
                if (tx_collision_bit)
                    next_state = ST_IDLE;
                else if (scl_rise)
                    next_bitcnt = bitcnt + 4'h1;
                else if (scl_fall)
                begin
                    next_shreg = {shreg[6:0], 1'b0};
                    if (byte_full)
                        next_state = ST_TXACK;
                end
            end
            ST_TXACK:
            begin
                if (scl_fall)
                    next_state = ST_HOLD;
            end
        endcase
        if (!enable || stop_det)
            next_state = ST_IDLE;
        if (enable && start_det)
        begin
            next_state  = ST_ADDR;
            next_phase  = PH_ADDR;
            next_bitcnt = 4'h0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state    <= ST_IDLE;
            phase    <= PH_ADDR;
            bitcnt   <= 4'h0;
            shreg    <= `ICSAM_RST_BYTE;
            ack_nack <= 1'b0;
            ack_fin  <= 1'b0;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end
        else if (ce)
        begin
            state    <= next_state;
            phase    <= next_phase;
            bitcnt   <= next_bitcnt;
            shreg    <= next_shreg;
            ack_nack <= next_nack;
            ack_fin  <= next_fin;
            scl_d    <= scl_s;
            sda_d    <= sda_s;
        end
    end

    // status flags: a set in the clearing cycle wins
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            data_flag    <= 1'b0;
            address_or_stop_flag   <= 1'b0;
            collision_bit   <= 1'b0;
            bus_error_flag <= 1'b0;
        end
        else if (ce)
        begin
            data_flag    <= set_dif || (data_flag && !flag_clr
                      && !(stat_wr && wdat[`ICSAM_ST_DIF]));
            address_or_stop_flag   <= set_address_or_stop_flag || (address_or_stop_flag && !flag_clr
                      && !(stat_wr && wdat[`ICSAM_ST_ADDRESS_OR_STOP_FLAG]));
            collision_bit   <= set_collision_bit || (collision_bit && !start_det
                      && !(stat_wr && wdat[`ICSAM_ST_COLLISION_BIT]));
            bus_error_flag <= set_berr || (bus_error_flag
                      && !(stat_wr && wdat[`ICSAM_ST_BUS_ERROR_FLAG]));
        end
    end

    // cause, direction, host acknowledge
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ap    <= 1'b0;
            dir   <= 1'b0;
            received_acknowledge <= 1'b0;
        end
        else if (ce)
        begin
            if (addr_hit)
            begin
                ap  <= 1'b1;
                dir <= shreg[0];
            end
            else if (stop_rep)
                ap <= 1'b0;
            if (state == ST_TXACK && scl_rise)
                received_acknowledge <= sda_s;
        end
    end

    // software registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            addr_reg <= `ICSAM_RST_BYTE;
            data_reg <= `ICSAM_RST_BYTE;
            mask_reg <= `ICSAM_RST_BYTE;
            ctrla    <= `ICSAM_RST_BYTE;
            acknowledge_action   <= 1'b0;
            ext_en   <= 1'b0;
        end
        else if (ce)
        begin
            if (wr && hit_ad)
                addr_reg <= wdat;
            if (wr && hit_mk)
                mask_reg <= wdat;
            if (wr && hit_ca)
                ctrla <= wdat & `ICSAM_CTRLA_MASK;
            if (wr && hit_cb)
                acknowledge_action <= wdat[`ICSAM_CB_ACKNOWLEDGE_ACTION];
            if (wr && hit_ex)
                ext_en <= wdat[0];
            if (data_wr)
                data_reg <= wdat;
            else if (state == ST_RX && scl_fall && byte_full)
                data_reg <= shreg;
        end
    end

    // bus answer: one wait state, then pready for one cycle
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            apb_rsp <= '0;
            pins    <= '0;
        end
        else if (ce)
        begin
            apb_rsp.pready  <= apb_req.psel && apb_req.penable
                               && !apb_rsp.pready;
            apb_rsp.pslverr <= apb_req.psel && apb_req.penable
                               && !apb_rsp.pready && !hit_any;
            apb_rsp.prdata  <= {24'h000000, rd_mux};
            pins.scl_oe     <= clock_hold;
            pins.sda_oe     <= drive_low;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_rx_end;
        ce && state == ST_RX && scl_fall && byte_full;
    endsequence

    sequence s_hold_entry;
        ce && state != ST_HOLD && next_state == ST_HOLD;
    endsequence

    a_rx_byte_done: assert property (
        s_rx_end |=> data_flag && state == ST_HOLD)
        else $error("received byte did not raise data flag");
    a_dif_clear: assert property (
        (ce && flag_clr && !set_dif) |=> !data_flag)
        else $error("data flag not cleared by access");
    a_address_or_stop_flag_clear: assert property (
        (ce && flag_clr && !set_address_or_stop_flag) |=> !address_or_stop_flag)
        else $error("address flag not cleared by access");
    a_addr_flag: assert property (
        (ce && addr_hit) |=> address_or_stop_flag && ap && clock_hold)
        else $error("address match did not set flag and cause");
    a_stop_cause: assert property (
        (ce && stop_rep) |=> address_or_stop_flag && !ap && state == ST_IDLE)
        else $error("reported stop did not set flag with stop cause");
    a_hold_scl: assert property (
        s_hold_entry |=> (data_flag || address_or_stop_flag) ##1 pins.scl_oe)
        else $error("clock hold without flag or pin drive");
    a_tx_collision: assert property (
        (ce && tx_collision_bit) |=> collision_bit && data_flag && state == ST_IDLE)
        else $error("lost high bit not reported as collision");
    a_collision_bit_clear: assert property (
        (ce && start_det && !set_collision_bit) |=> !collision_bit)
        else $error("collision not cleared by start");
    a_bus_error_flag_gate: assert property (
        $rose(bus_error_flag) |-> $past(ext_en))
        else $error("bus error set while detection disabled");
    a_received_acknowledge_cap: assert property (
        (ce && state == ST_TXACK && scl_rise) |=> received_acknowledge == $past(sda_s))
        else $error("host acknowledge not captured");
    a_smart_ack: assert property (
        (ce && clock_hold && data_rd && smart && phase != PH_TX
         && enable && !stop_det && !start_det)
        |=> state == ST_ACK && ack_nack == $past(acknowledge_action))
        else $error("smart read did not run acknowledge action");
endmodule

`default_nettype wire

/* File: rtl/icsam_match.sv */
/*
 Client address comparator: primary address with mask or second
 address, general call, and accept-all mode.
 Assumes stable register inputs while a received address is judged.
*/
`timescale 1ns/10ps
`default_nettype none

module icsam_match
(
    // received address
    input  wire logic [6:0] rx_addr,
    // configuration
    input  wire logic [7:0] own_addr,
    input  wire logic [7:0] mask_reg,
    input  wire logic       promisc,
    // result
    output logic            hit
);
    wire logic gen_call = own_addr[0] && (rx_addr == 7'h00);
    wire logic masked_eq =
        ((rx_addr ^ own_addr[7:1]) & ~mask_reg[7:1]) == 7'h00;
    wire logic second_eq =
        (rx_addr == own_addr[7:1]) || (rx_addr == mask_reg[7:1]);

    assign hit = promisc || gen_call
                 || (mask_reg[0] ? second_eq : masked_eq);
endmodule

`default_nettype wire

/* File: rtl/icsam_pkg.sv */
/*
 Types shared by the two-wire client: bus request and answer,
 pin drive group, protocol states and transfer phases.
 Assumes nothing of its surroundings.
*/
package icsam_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } icsam_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } icsam_apb_rsp_t;

    typedef struct packed {
        logic scl_out;
        logic scl_oe;
        logic sda_out;
        logic sda_oe;
    } icsam_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_RX, ST_HOLD, ST_ACK, ST_TX, ST_TXACK
    } icsam_state_t;

    typedef enum logic [1:0] {PH_ADDR, PH_RX, PH_TX} icsam_phase_t;

endpackage

/* File: rtl/icsam_sync.sv */
/*
 Two-flop synchroniser for a group of pin inputs.
 Assumes the inputs are asynchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none

module icsam_sync
#(
    parameter int W = 2
)
(
    // system
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic         ce,
    // data
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            meta <= '1;
            q    <= '1;
        end
        else if (ce)
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

`default_nettype wire

/* File: test/icsam_host.sv */
/*
 Bus host model: open-drain pulls on SCL and SDA, 160 ns clock.
 Assumes pull-ups resolve released wires high.
*/
`timescale 1ns/10ps
`default_nettype none

module icsam_host
(
    // bus wires
    input  wire logic scl,
    input  wire logic sda,
    // pulls, high drives the wire low
    output var  logic scl_pull,
    output var  logic sda_pull
);
    // count of clock stretches that never ended
    int stalls = 0;

    initial
    begin
        scl_pull = 1'h0;
        sda_pull = 1'h0;
    end

    // release SCL, waiting out clock stretching
    task automatic rise;
        scl_pull = 1'h0;
        for (int n = 0; n < 2000 && scl !== 1'h1; n++)
            #10;
        if (scl !== 1'h1)
            stalls++;
    endtask

    task automatic start;
        sda_pull = 1'h0;
        #40;
        rise();
        #40;
        sda_pull = 1'h1;
        #80;
        scl_pull = 1'h1;
        #40;
    endtask

    task automatic stop;
        sda_pull = 1'h1;
        #40;
        rise();
        #80;
        sda_pull = 1'h0;
        #80;
    endtask

    // sending 1 releases SDA so the client may drive it
    // 80 ns low, 80 ns high; edges fall between system clock edges
    task automatic bitx(input logic o, output logic i);
        sda_pull = ~o;
        #30;
        rise();
        #40;
        i = sda;
        #40;
        scl_pull = 1'h1;
        #50;
    endtask

    // start directly followed by stop, SCL high throughout
    task automatic blip;
        sda_pull = 1'h0;
        rise();
        #80;
        sda_pull = 1'h1;
        #80;
        sda_pull = 1'h0;
        #80;
    endtask

    // msb first
    task automatic bytex(input logic [7:0] o, output logic [7:0] i);
        for (int k = 7; k >= 0; k--)
            bitx(o[k], i[k]);
    endtask
endmodule
`default_nettype wire

/* File: test/test_icsam_client.sv */
/*
 Bench for the two-wire client: APB master, host model, scenarios.
 Assumes the pull-up resolution of both wires is done here.
*/
`timescale 1ns/10ps
`default_nettype none
`include "icsam_cfg.svh"

module test_icsam_client;
    import icsam_pkg::*;

    localparam logic [5:0] ST = `ICSAM_IDX_STATUS;
    localparam logic [5:0] CA = `ICSAM_IDX_CTRLA;
    localparam logic [5:0] CB = `ICSAM_IDX_CTRLB;
    localparam logic [5:0] AD = `ICSAM_IDX_ADDR;
    localparam logic [5:0] MK = `ICSAM_IDX_MASK;

    logic           clk_sys;
    logic           reset;
    icsam_apb_req_t req;
    icsam_apb_rsp_t rsp;
    icsam_pins_t    pins;
    logic           hs;
    logic           hd;
    logic [7:0]     rd;
    logic [7:0]     hb;
    logic           b;
    int             failures;
    int             check_count;
    wire logic      scl = ~(hs | pins.scl_oe);
    wire logic      sda = ~(hd | pins.sda_oe);

    icsam_client i_icsam_client
    (
        .clk_sys(clk_sys), .reset(reset), .ce(1'h1),
        .apb_req(req), .apb_rsp(rsp),
        .scl_in(scl), .sda_in(sda), .pins(pins)
    );

    icsam_host i_icsam_host
    (
        .scl(scl), .sda(sda), .scl_pull(hs), .sda_pull(hd)
    );

    task automatic end_sim;
        failures += i_icsam_host.stalls;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tmo(input logic ok);
        if (!ok)
        begin
            failures++;
            end_sim();
        end
    endtask

    // one APB transfer; read data to rd, error to b
    task automatic apb(input logic w, input logic [5:0] a,
                       input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{1'h1, 1'h0, w, {a, 2'h0}, {24'h0, d}};
        @(posedge clk_sys);
        req.penable <= 1'h1;
        for (int n = 0; n < 20; n++)
        begin
            @(posedge clk_sys);
            if (rsp.pready === 1'h1)
                break;
        end
        tmo(rsp.pready === 1'h1);
        rd = rsp.prdata[7:0];
        b = rsp.pslverr;
        req.psel <= 1'h0;
        req.penable <= 1'h0;
    endtask

    task automatic rchk(input logic [5:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        apb(1'h0, a, 8'h00);
        chk(rd & m, e);
    endtask

    // poll status until clock hold reads 1
    task automatic hold;
        for (int n = 0; n < 40; n++)
        begin
            apb(1'h0, ST, 8'h00);
            if (rd[5] === 1'h1)
                break;
        end
        tmo(rd[5] === 1'h1);
    endtask

    task automatic addr(input logic [7:0] a);
        i_icsam_host.start();
        i_icsam_host.bytex(a, hb);
        hold();
    endtask

    task automatic t_write;
        rchk(ST, 8'hFF, 8'h00);
        rchk(AD, 8'hFF, 8'h00);
        apb(1'h0, 6'h20, 8'h00);
        chk({7'h00, b}, 8'h01);
        apb(1'h1, AD, 8'hA0);
        apb(1'h1, CA, 8'h23);
        addr(8'hA0);
        chk(rd & 8'hEF, 8'h61);
        apb(1'h1, CB, 8'h03);
        rchk(ST, 8'hE0, 8'h00);
        i_icsam_host.bitx(1'h1, b);
        chk({7'h00, b}, 8'h00);
        i_icsam_host.bytex(8'h3C, hb);
        hold();
        chk(rd & 8'hE0, 8'hA0);
        rchk(`ICSAM_IDX_DATA, 8'hFF, 8'h3C);
        rchk(ST, 8'hC0, 8'h00);
        i_icsam_host.bitx(1'h1, b);
        chk({7'h00, b}, 8'h00);
        i_icsam_host.stop();
        rchk(ST, 8'h41, 8'h40);
        apb(1'h1, CB, 8'h02);
        $display("test write done");
    endtask

    task automatic t_match;
        logic [31:0] tab [5] = '{32'hA0_00_01_A4, 32'hA0_04_01_A4,
            32'hA0_67_01_66, 32'hA1_00_01_00, 32'hA0_00_05_24};
        logic [4:0]  hit = 5'h1E;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'h1, AD, tab[i][31:24]);
            apb(1'h1, MK, tab[i][23:16]);
            apb(1'h1, CA, tab[i][15:8]);
            i_icsam_host.start();
            i_icsam_host.bytex(tab[i][7:0], hb);
            if (hit[i])
            begin
                hold();
                apb(1'h1, CB, 8'h02);
            end
            i_icsam_host.bitx(1'h1, b);
            chk({7'h00, b}, {7'h00, ~hit[i]});
            i_icsam_host.stop();
            rchk(ST, 8'h40, 8'h00);
        end
        $display("test match done");
    endtask

    task automatic t_read;
        apb(1'h1, AD, 8'hA0);
        apb(1'h1, MK, 8'h00);
        apb(1'h1, CA, 8'h01);
        addr(8'hA1);
        chk(rd & 8'hEF, 8'h63);
        apb(1'h1, CB, 8'h03);
        i_icsam_host.bitx(1'h1, b);
        hold();
        chk(rd & 8'hE0, 8'hA0);
        apb(1'h1, `ICSAM_IDX_DATA, 8'hA5);
        i_icsam_host.bytex(8'hFF, hb);
        chk(hb, 8'hA5);
        i_icsam_host.bitx(1'h1, b);
        hold();
        chk(rd & 8'h90, 8'h90);
        apb(1'h1, CB, 8'h02);
        i_icsam_host.stop();
        $display("test read done");
    endtask

    task automatic t_collision_bit;
        addr(8'hA1);
        apb(1'h1, CB, 8'h03);
        i_icsam_host.bitx(1'h1, b);
        hold();
        apb(1'h1, `ICSAM_IDX_DATA, 8'hFF);
        i_icsam_host.bytex(8'h00, hb);
        rchk(ST, 8'h88, 8'h88);
        i_icsam_host.start();
        rchk(ST, 8'h08, 8'h00);
        i_icsam_host.stop();
        i_icsam_host.blip();
        rchk(ST, 8'h04, 8'h00);
        apb(1'h1, `ICSAM_IDX_EXT, 8'h01);
        i_icsam_host.blip();
        rchk(ST, 8'h04, 8'h04);
        apb(1'h1, ST, 8'h04);
        rchk(ST, 8'h04, 8'h00);
        addr(8'hA0);
        apb(1'h1, CB, 8'h06);
        i_icsam_host.bitx(1'h0, b);
        rchk(ST, 8'h08, 8'h08);
        i_icsam_host.stop();
        $display("test collision done");
    endtask

    initial
    begin
        clk_sys = 1'h0;
        forever
            #10 clk_sys = ~clk_sys;
    end

    initial
    begin
        failures = 0;
        check_count = 0;
        req = '0;
        reset = 1'h1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'h0;
        t_write();
        t_match();
        t_read();
        t_collision_bit();
        end_sim();
    end
endmodule
`default_nettype wire
